// ### security_erase_freeze_cmd_test.sv
// Self-checking bench for the erase and freeze block.
// Assumes the package, top and media model are compiled first.
`timescale 1ns/10ps
`default_nettype none
`define CK(n, e, g) begin n_tests++; if ((g) !== (e)) begin mismatches++; $display("mismatch %s exp %0h got %0h", n, e, g); end end
module security_erase_freeze_cmd_test;
	import sefc_pkg::*;
	logic clock, rst, por, crc_err, lock_enabled, word_req, lock_disable, frozen, media_wr_req, media_wr_done, media_wr_fail, fail_on;
	logic [7:0] command_error_flags, device_status_flags, media_wr_lba, sum;
	logic [15:0] erase_time_word;
	logic [255:0] user_pw, master_pw;
	logic [7:0] ops [4] = '{8'hF1, 8'hF2, 8'hF4, 8'hF6};
	int mismatches, n_tests, ld_n, cyc, i, seed = 32'h5b48e066;
	sefc_cmd_t cmd;
	sefc_word_t wr_word;
	sefc_top #(.LBA_W(8), .ERASE_MINUTES(16'h0A5C)) u_dut (.*, .native_max_lba(8'h04));
	// Fail only the top sector so the whole range is still walked
	sefc_media_model u_media (.clock(clock), .rst(rst), .req(media_wr_req), .fail_en(fail_on && media_wr_lba == 8'h04),
		.done(media_wr_done), .fail(media_wr_fail));
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	// Sum of written sectors shows the range 0..4 was covered
	always @(posedge clock) begin
		if (media_wr_done === 1'b1) sum += media_wr_lba;
		if (lock_disable === 1'b1) ld_n++;
		cyc++;
		if (cyc > 20000) begin
			mismatches++;
			wrap_up();
		end
	end
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic go(input logic [7:0] op);
		@(posedge clock) #1 cmd = '{1'b1, op};
		@(posedge clock) #1 cmd.valid = 1'b0;
	endtask
	task automatic chk(input logic [7:0] st, input logic [7:0] er, input logic [7:0] s, input int ld);
		`CK("status", st, device_status_flags)
		`CK("error", er, command_error_flags)
		`CK("lba_sum", s, sum)
		`CK("unlock", ld, ld_n)
		sum = 8'h00;
		ld_n = 0;
	endtask
	// Reserved words are random; a CRC pulse lands once the sector is in
	task automatic ers(input logic arm, input logic [15:0] w0, input logic [255:0] pw, input logic crc);
		if (arm) go(8'hF3);
		go(8'hF4);
		repeat (2) @(posedge clock);
		#1;
		for (int k = 0; k < 256 && word_req === 1'b1; k++) begin
			@(posedge clock) #1 wr_word = '{1'b1, k == 0 ? w0 : k < 17 ? pw[16 * k - 16 +: 16] : 16'($random(seed))};
			@(posedge clock) #1 wr_word.valid = 1'b0;
		end
		crc_err = crc;
		@(posedge clock) #1 crc_err = 1'b0;
		for (int k = 0; k < 400 && (word_req || device_status_flags[7]); k++)
			@(posedge clock) #1;
		// Unlock pulse rises in the same cycle as the final status; one more edge lets the counter see it
		@(posedge clock) #1;
	endtask
	initial begin
		rst = 1'b1;
		por = 1'b1;
		cmd = '0;
		wr_word = '0;
		crc_err = 1'b0;
		lock_enabled = 1'b0;
		fail_on = 1'b0;
		sum = 8'h00;
		for (i = 0; i < 8; i++) begin
			user_pw[i * 32 +: 32] = $random(seed);
			master_pw[i * 32 +: 32] = $random(seed);
		end
		repeat (4) @(posedge clock);
		#1 rst = 1'b0;
		por = 1'b0;
		`CK("time_word", 16'h0A5C, erase_time_word)
		ers(0, 16'h0000, user_pw, 0);
		chk(8'h51, 8'h04, 0, 0);
		ers(1, 16'h0000, user_pw, 0);
		chk(8'h51, 8'h04, 0, 0);
		ers(1, 16'h0001, ~master_pw, 0);
		chk(8'h50, 8'h00, 8'h0A, 1);
		lock_enabled = 1'b1;
		ers(1, 16'h0001, master_pw, 1);
		chk(8'h51, 8'h80, 8'h0A, 1);
		ers(1, 16'h0000, master_pw, 0);
		chk(8'h51, 8'h04, 0, 0);
		ers(1, 16'h0002, user_pw, 0);
		chk(8'h51, 8'h04, 0, 0);
		fail_on = 1'b1;
		ers(1, 16'h0000, user_pw, 0);
		chk(8'h51, 8'h04, 8'h0A, 0);
		fail_on = 1'b0;
		go(8'hF3);
		go(8'hE7);
		ers(0, 16'h0000, user_pw, 0);
		chk(8'h51, 8'h04, 0, 0);
		ers(1, 16'h0000, user_pw, 0);
		chk(8'h50, 8'h00, 8'h0A, 1);
		go(8'hF5);
		`CK("frozen", 1'b1, frozen)
		for (i = 0; i < 4; i++) begin
			go(ops[i]);
			chk(8'h51, 8'h04, 0, 0);
		end
		ers(1, 16'h0000, user_pw, 0);
		chk(8'h51, 8'h04, 0, 0);
		@(posedge clock) #1 rst = 1'b1;
		@(posedge clock) #1 rst = 1'b0;
		`CK("frozen", 1'b1, frozen)
		@(posedge clock) #1 por = 1'b1;
		@(posedge clock) #1 por = 1'b0;
		`CK("frozen", 1'b0, frozen)
		wrap_up();
	end
endmodule
`default_nettype wire

// ### sefc_cfg.svh
// Constants for the security erase and freeze command block.
// Assumes inclusion by the package and by the design modules.
`ifndef SEFC_CFG_SVH
`define SEFC_CFG_SVH
`define SEFC_OP_PREPARE 8'hF3
`define SEFC_OP_ERASE 8'hF4
`define SEFC_OP_FREEZE 8'hF5
`define SEFC_OP_SET_PW 8'hF1
`define SEFC_OP_UNLOCK 8'hF2
`define SEFC_OP_DISABLE_PW 8'hF6
`define SEFC_ERR_ABT 2
`define SEFC_ERR_IDN 4
`define SEFC_ERR_CRC 7
`define SEFC_ST_BSY 7
`define SEFC_ST_RDY 6
`define SEFC_ST_DSC 4
`define SEFC_ST_DRQ 3
`define SEFC_ST_ERR 0
`define SEFC_PW_SEL_BIT 0
`define SEFC_MODE_BIT 1
`define SEFC_PW_FIRST_WORD 8'h01
`define SEFC_PW_LAST_WORD 8'h10
`define SEFC_LAST_WORD 8'hFF
`define SEFC_ERR_RESET 8'h00
`define SEFC_ST_RESET 8'h50
`define SEFC_ERASE_TIME_WORD 8'h59
`endif

// ### sefc_media_model.sv
// Media side model: answers each zero-write request with a done pulse.
// Assumes the request holds until done is seen.
`timescale 1ns/10ps
`default_nettype none
module sefc_media_model (
	input wire logic clock,
	input wire logic rst,
	input wire logic req,
	input wire logic fail_en,
	output logic done,
	output logic fail
);
	logic [1:0] dly_q;
	logic slow_q;
	// Alternate prompt and slow answers; fail wobbles when not qualified by done
	always_ff @(posedge clock) begin
		done <= 1'b0;
		fail <= ~fail;
		if (rst) begin
			dly_q <= 2'h0;
			slow_q <= 1'b0;
			fail <= 1'b0;
		end else if (req && !done) begin
			dly_q <= dly_q + 2'h1;
			if (dly_q == {slow_q, slow_q}) begin
				done <= 1'b1;
				fail <= fail_en;
				dly_q <= 2'h0;
				slow_q <= ~slow_q;
			end
		end
	end
endmodule
`default_nettype wire

// ### sefc_monitor.sv
// Checker on the command block's top ports.
// Assumes one clock and that rst leaves frozen alone.
`timescale 1ns/10ps
`default_nettype none
module sefc_monitor
	import sefc_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic por,
	input wire sefc_cmd_t cmd,
	input wire logic [7:0] command_error_flags,
	input wire logic [7:0] device_status_flags,
	input wire logic word_req,
	input wire logic lock_disable,
	input wire logic frozen,
	input wire logic media_wr_req
);
	logic armed_q, armed_d, take;
	// Commands are only taken while neither busy nor asking for data
	assign take = !device_status_flags[7] && !word_req && cmd.valid && !por;
	// Prepare arms, any other taken command disarms
	always_comb armed_d = take ? cmd.opcode == 8'hF3 : armed_q;
	always_ff @(posedge clock) armed_q <= rst ? 1'b0 : armed_d;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	chk_freeze_now: assert property (take && cmd.opcode == 8'hF5 |=> frozen)
		else $error("no freeze");
	chk_frozen_holds: assert property (frozen && !por |=> frozen)
		else $error("freeze lost");
	chk_frozen_reject: assert property (take && frozen && cmd.opcode inside {8'hF1, 8'hF2, 8'hF4, 8'hF6}
		|=> command_error_flags == 8'h04 && device_status_flags == 8'h51) else $error("frozen accepted");
	chk_bare_erase: assert property (take && cmd.opcode == 8'hF4 && !armed_q
		|=> command_error_flags == 8'h04 && device_status_flags == 8'h51) else $error("unarmed erase");
	chk_xfer_quiet: assert property (word_req |-> !device_status_flags[7] && !media_wr_req)
		else $error("drq clash");
	chk_busy_wipe: assert property (media_wr_req |-> device_status_flags[7])
		else $error("wipe idle");
	chk_unlock_pulse: assert property (lock_disable |=> !lock_disable)
		else $error("unlock long");
	chk_abort_flags: assert property (command_error_flags[2] |-> device_status_flags[0] && !device_status_flags[7])
		else $error("abort flags");
	cover property (lock_disable);
	cover property (take && frozen);
	cover property (media_wr_req);
endmodule
bind sefc_top sefc_monitor u_mon (.*);
`default_nettype wire

// ### sefc_pkg.sv
// Types shared by the security erase and freeze command block.
// Assumes sefc_cfg.svh is on the include path.
`include "sefc_cfg.svh"
package sefc_pkg;
	// Taskfile command handed in by the host side
	typedef struct packed {
		logic valid;
		logic [7:0] opcode;
	} sefc_cmd_t;
	// One word of the parameter sector
	typedef struct packed {
		logic valid;
		logic [15:0] data;
	} sefc_word_t;
	typedef enum logic [2:0] {
		SEFC_IDLE = 3'b000,
		SEFC_XFER = 3'b001,
		SEFC_CHECK = 3'b010,
		SEFC_WIPE = 3'b011,
		SEFC_DONE = 3'b100
	} sefc_state_t;
endpackage

// ### sefc_top.sv
// Security erase and freeze command interpreter of a disk drive.
// Assumes a taskfile front end that delivers opcodes, sector words and CRC flags.
// Behaviour
// - Opcode F4h is secure erase then unlock
// - Erase from zero to native top address
// - Request exactly one parameter sector first
// - Abort when unlocked and user selected
// - Abort on stored password mismatch
// - Write zeros, no verify, keep defects
// - Abort erase without immediately preceding prepare
// - Success disables lock, keeps master password
// - Unlocked with master selected: skip compare, just erase
// - Erase duration reported in identify word 89
// - Word zero bit 0 selects password
// - Mode bit 1, reserved, 32-byte password
// - Enhanced mode set means abort
// - Abort on bad password or failed wipe
// - CRC error may complete with error
// - Opcode F5h freezes at once
// - Frozen rejects all lock-changing commands
// - Frozen lasts until power removed
// - Prepare F3h, no data, arms erase
`timescale 1ns/10ps
`default_nettype none
module sefc_top
	import sefc_pkg::*;
#(
	parameter int LBA_W = 48,
	parameter logic [15:0] ERASE_MINUTES = 16'h0001
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic por,
	input wire sefc_cmd_t cmd,
	input wire sefc_word_t wr_word,
	input wire logic crc_err,
	input wire logic [LBA_W-1:0] native_max_lba,
	input wire logic lock_enabled,
	input wire logic [255:0] user_pw,
	input wire logic [255:0] master_pw,
	output logic [7:0] command_error_flags,
	output logic [7:0] device_status_flags,
	output logic word_req,
	output logic lock_disable,
	output logic frozen,
	output logic [15:0] erase_time_word,
	output logic media_wr_req,
	output logic [LBA_W-1:0] media_wr_lba,
	input wire logic media_wr_done,
	input wire logic media_wr_fail
);
	logic [7:0] err_q, err_d, st_q, st_d;
	sefc_state_t state_q, state_d;
	logic armed_q, armed_d;
	logic frozen_q, frozen_d;
	logic [7:0] widx_q, widx_d;
	logic sel_q, sel_d, mode_q, mode_d, crc_q, crc_d;
	logic [255:0] pw_q, pw_d;
	logic unlock_q, unlock_d;
	logic wipe_go, wipe_fin, wipe_bad;
	logic [15:0] time_q;
	logic [15:0] pw_hit;
	logic [255:0] pw_ref;
	genvar gi;

	// Commands that would change the lock feature
	function automatic logic lock_cmd(input logic [7:0] op);
		lock_cmd = (op == `SEFC_OP_SET_PW) || (op == `SEFC_OP_UNLOCK) ||
			(op == `SEFC_OP_DISABLE_PW) || (op == `SEFC_OP_ERASE);
	endfunction

	// Status byte for a finished command
	function automatic logic [7:0] fin_status(input logic fail);
		logic [7:0] s;
		s = '0;
		s[`SEFC_ST_RDY] = 1'b1;
		s[`SEFC_ST_DSC] = 1'b1;
		s[`SEFC_ST_ERR] = fail;
		fin_status = s;
	endfunction

	sefc_wiper #(
		.LBA_W(LBA_W)
	) u_wiper (
		.clock(clock),
		.rst(rst),
		.start(wipe_go),
		.last_lba(native_max_lba),
		.wr_req(media_wr_req),
		.wr_lba(media_wr_lba),
		.wr_done(media_wr_done),
		.wr_fail(media_wr_fail),
		.fin(wipe_fin),
		.bad(wipe_bad)
	);

	// Freeze state: survives soft reset, only power-on clears it
	always_comb begin
		frozen_d = frozen_q;
		if (state_q == SEFC_IDLE && cmd.valid && cmd.opcode == `SEFC_OP_FREEZE)
			frozen_d = 1'b1;
	end
	always_ff @(posedge clock) begin
		if (por)
			frozen_q <= 1'b0;
		else
			frozen_q <= frozen_d;
	end

	// Word-by-word password compare; sixteen narrow equalities keep the 256-bit
	// comparator shallow instead of one wide chain
	assign pw_ref = sel_q ? master_pw : user_pw;
	generate
		for (gi = 0; gi < 16; gi++) begin : g_pw
			assign pw_hit[gi] = (pw_q[gi * 16 +: 16] == pw_ref[gi * 16 +: 16]);
		end
	endgenerate

	// Identify word held in a flop so every top output is registered
	always_ff @(posedge clock) begin
		time_q <= ERASE_MINUTES;
	end

	// Command sequencer
	always_comb begin
		state_d = state_q;
		err_d = err_q;
		st_d = st_q;
		armed_d = armed_q;
		widx_d = widx_q;
		sel_d = sel_q;
		mode_d = mode_q;
		crc_d = crc_q | crc_err;
		pw_d = pw_q;
		unlock_d = 1'b0;
		wipe_go = 1'b0;
		case (state_q)
			SEFC_IDLE: begin
				crc_d = 1'b0;
				if (cmd.valid) begin
					err_d = `SEFC_ERR_RESET;
					armed_d = 1'b0;
					if (frozen_q && lock_cmd(cmd.opcode)) begin
						err_d[`SEFC_ERR_ABT] = 1'b1;
						st_d = fin_status(1'b1);
					end else if (cmd.opcode == `SEFC_OP_PREPARE) begin
						armed_d = 1'b1;
						st_d = fin_status(1'b0);
					end else if (cmd.opcode == `SEFC_OP_FREEZE) begin
						st_d = fin_status(1'b0);
					end else if (cmd.opcode == `SEFC_OP_ERASE) begin
						if (!armed_q) begin
							err_d[`SEFC_ERR_ABT] = 1'b1;
							st_d = fin_status(1'b1);
						end else begin
							widx_d = '0;
							st_d = '0;
							st_d[`SEFC_ST_RDY] = 1'b1;
							st_d[`SEFC_ST_DSC] = 1'b1;
							st_d[`SEFC_ST_DRQ] = 1'b1;
							state_d = SEFC_XFER;
						end
					end else begin
						st_d = fin_status(1'b0);
					end
				end
			end
			SEFC_XFER: begin
				// One sector of 256 words, then stop asking
				if (wr_word.valid) begin
					if (widx_q == '0) begin
						sel_d = wr_word.data[`SEFC_PW_SEL_BIT];
						mode_d = wr_word.data[`SEFC_MODE_BIT];
					end else if (widx_q >= `SEFC_PW_FIRST_WORD && widx_q <= `SEFC_PW_LAST_WORD) begin
						pw_d = {wr_word.data, pw_q[255:16]};
					end
					widx_d = widx_q + 8'h01;
					if (widx_q == `SEFC_LAST_WORD) begin
						st_d[`SEFC_ST_DRQ] = 1'b0;
						st_d[`SEFC_ST_BSY] = 1'b1;
						state_d = SEFC_CHECK;
					end
				end
			end
			SEFC_CHECK: begin
				if (mode_q) begin
					err_d[`SEFC_ERR_ABT] = 1'b1;
					st_d = fin_status(1'b1);
					state_d = SEFC_IDLE;
				end else if (!lock_enabled && !sel_q) begin
					err_d[`SEFC_ERR_ABT] = 1'b1;
					st_d = fin_status(1'b1);
					state_d = SEFC_IDLE;
				end else if (lock_enabled && !(&pw_hit)) begin
					err_d[`SEFC_ERR_ABT] = 1'b1;
					st_d = fin_status(1'b1);
					state_d = SEFC_IDLE;
				end else begin
					wipe_go = 1'b1;
					state_d = SEFC_WIPE;
				end
			end
			SEFC_WIPE: begin
				if (wipe_fin)
					state_d = SEFC_DONE;
			end
			SEFC_DONE: begin
				if (wipe_bad) begin
					err_d[`SEFC_ERR_ABT] = 1'b1;
					st_d = fin_status(1'b1);
				end else begin
					unlock_d = 1'b1;
					err_d[`SEFC_ERR_CRC] = crc_q;
					st_d = fin_status(crc_q);
				end
				state_d = SEFC_IDLE;
			end
			default: state_d = SEFC_IDLE;
		endcase
	end
	always_ff @(posedge clock) begin
		if (rst) begin
			state_q <= SEFC_IDLE;
			err_q <= `SEFC_ERR_RESET;
			st_q <= `SEFC_ST_RESET;
			armed_q <= 1'b0;
			widx_q <= '0;
			sel_q <= 1'b0;
			mode_q <= 1'b0;
			crc_q <= 1'b0;
			pw_q <= '0;
			unlock_q <= 1'b0;
		end else begin
			state_q <= state_d;
			err_q <= err_d;
			st_q <= st_d;
			armed_q <= armed_d;
			widx_q <= widx_d;
			sel_q <= sel_d;
			mode_q <= mode_d;
			crc_q <= crc_d;
			pw_q <= pw_d;
			unlock_q <= unlock_d;
		end
	end

	// Outputs straight from flip-flops; erase time is a constant word
	assign command_error_flags = err_q;
	assign device_status_flags = st_q;
	assign word_req = st_q[`SEFC_ST_DRQ];
	assign lock_disable = unlock_q;
	assign frozen = frozen_q;
	assign erase_time_word = time_q;
endmodule
`default_nettype wire

// ### sefc_wiper.sv
// Sequencer that writes zeros over a sector range, one request at a time.
// Assumes the media side answers each write with a done pulse and a fail flag.
`timescale 1ns/10ps
`default_nettype none
module sefc_wiper
	import sefc_pkg::*;
#(
	parameter int LBA_W = 48
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic start,
	input wire logic [LBA_W-1:0] last_lba,
	output logic wr_req,
	output logic [LBA_W-1:0] wr_lba,
	input wire logic wr_done,
	input wire logic wr_fail,
	output logic fin,
	output logic bad
);
	logic run_q, run_d;
	logic [LBA_W-1:0] lba_q, lba_d;
	logic fin_q, fin_d, bad_q, bad_d;
	// Walk from sector zero to the native top; no read-back, no defect list update
	always_comb begin
		run_d = run_q;
		lba_d = lba_q;
		fin_d = 1'b0;
		bad_d = bad_q;
		if (start) begin
			run_d = 1'b1;
			lba_d = '0;
			bad_d = 1'b0;
		end else if (run_q && wr_done) begin
			if (wr_fail) begin
				bad_d = 1'b1;
				run_d = 1'b0;
				fin_d = 1'b1;
			end else if (lba_q == last_lba) begin
				run_d = 1'b0;
				fin_d = 1'b1;
			end else begin
				lba_d = lba_q + LBA_W'(1);
			end
		end
	end
	always_ff @(posedge clock) begin
		if (rst) begin
			run_q <= 1'b0;
			lba_q <= '0;
			fin_q <= 1'b0;
			bad_q <= 1'b0;
		end else begin
			run_q <= run_d;
			lba_q <= lba_d;
			fin_q <= fin_d;
			bad_q <= bad_d;
		end
	end
	assign wr_req = run_q;
	assign wr_lba = lba_q;
	assign fin = fin_q;
	assign bad = bad_q;
endmodule
`default_nettype wire
